// File: core/fault_recorder_defs.svh
/*
 fault history recorder: register offsets, field positions and reset values.
 assumes a byte-addressed APB slave with one 32-bit word per register.
*/
`ifndef FAULT_RECORDER_DEFS_SVH
`define FAULT_RECORDER_DEFS_SVH

`define OFS_STATUS 8'h00
`define OFS_CHANNEL 8'h04
`define OFS_BUS_RESET 8'h08
`define OFS_LOCK_SELECT 8'h0C
`define OFS_LOCK_PASSWORD 8'h10
`define OFS_UNLOCK 8'h14
`define OFS_EDIT_INDEX 8'h18
`define OFS_EDIT_VALUE 8'h1C
`define OFS_PARAM_VALUE 8'h20
`define OFS_EDIT_STATUS 8'h24

`define REGION_CTRL 2'h0
`define REGION_SNAP 2'h1
`define REGION_HIST 2'h2
`define CTRL_WORDS 4'hA

`define QTY_WORDS 9
`define SNAP_WORDS 4'hD
`define SNAP_CMD 4'h9
`define SNAP_COND 4'hA
`define SNAP_ACCUM 4'hB
`define SNAP_INTERVAL 4'hC

`define DIG_CMD 0
`define DIG_MODE 3:0
`define DIG_RUN 7:4
`define DIG_REGEN 11:8
`define DIG_LIMIT 15:12

`define KEY_STOP 0
`define KEY_OK 1
`define KEY_TERM 2
`define KEY_COUNT 3

`define LOCK_NONE 2'h0
`define RST_PASSWORD 16'h0000
`define RST_LOCK_SELECT 2'h0

`endif

// File: core/fault_recorder_pkg.sv
/*
 types shared by the fault history recorder modules.
 assumes nothing of its surroundings.
*/
package fault_recorder_pkg;
    typedef enum logic [1:0] {
        CH_PANEL = 2'h0,
        CH_TERMINAL = 2'h1,
        CH_FIELDBUS = 2'h2
    } channel_type;

    typedef enum logic {
        BUS_IDLE = 1'h0,
        BUS_ANSWER = 1'h1
    } bus_state_type;
endpackage

// File: core/word_store_if.sv
/*
 port of a small word store: one write port, one read port with registered data.
 assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface word_store_if #(parameter int AW = 3, parameter int DW = 8);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport user (output we, waddr, wdata, raddr, input rdata);
    modport store (input we, waddr, wdata, raddr, output rdata);
endinterface

// File: core/pin_edge_sync.sv
/*
 two-stage synchroniser with rising-edge detect for external pins.
 assumes raw inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module pin_edge_sync #(parameter int WIDTH = 3) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // pins and results
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_edge_sync needs WIDTH of at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] prev;
    } state_type;

    state_type st;
    state_type next_st;

    always_comb begin
        next_st = st;
        next_st.stage1 = raw;
        next_st.stage2 = st.stage1;
        next_st.prev = st.stage2;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.stage2;
    assign rise = st.stage2 & ~st.prev;
endmodule

// File: core/word_store.sv
/*
 small word memory with synchronous write and registered read data.
 assumes the user holds raddr one cycle before it reads rdata.
*/
`timescale 1ns/1ps
module word_store #(parameter int AW = 3, parameter int DW = 8) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // access port
    word_store_if.store port
);
    if (AW < 1 || AW > 8 || DW < 1) begin : g_bad_shape
        $error("word_store shape out of range");
    end

    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
        logic [DW-1:0] rdata;
    } state_type;

    state_type st;
    state_type next_st;

    always_comb begin
        next_st = st;
        next_st.rdata = st.mem[port.raddr];
        if (port.we) begin
            next_st.mem[port.waddr] = port.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.rdata = st.rdata;
endmodule

// File: core/fault_history_recorder.sv
/*
 fault history recorder: last eight fault codes, a snapshot of drive quantities at
 the latest fault, fault reset from panel, terminal or fieldbus, and gated editing
 of function codes. assumes an APB master on ref_clk and drive logic on ref_clk;
 key and terminal pins are asynchronous.
*/
// Decided for this implementation: the APB slave port and the address map.
// Summary of operation
// RL1 - keep codes of the eight latest faults, slot zero newest
// RL2 - a new fault ages every slot by one and drops the oldest
// RL3 - capture nine drive quantities at the latest fault
// RL4 - capture running hours and hours since the previous fault
// RL5 - command word low digit: 0 stop, 1 run; other digits zero
// RL6 - condition word mode digit: 0..5 control mode
// RL7 - condition word run digit: 0..4 run state
// RL8 - condition word digit: 0 motoring, 1 regenerating
// RL9 - condition word limit digit: 0 none, 1 current, 2 over, 3 under voltage
// RL10 - stop/reset key clears the fault while its code is shown
// RL11 - terminal channel: fault-reset input clears the fault
// RL12 - fieldbus channel: host reset command clears the fault
// RL13 - host waits five minutes after overload or overheat before reset
// RL14 - terminal run command is withdrawn before a terminal reset
// RL15 - locked parameters change only after the matching password
// RL16 - codes flagged run-locked are refused while running
// RL17 - an edit takes effect only on the OK key
`timescale 1ns/1ps
`include "fault_recorder_defs.svh"
module fault_history_recorder
    import fault_recorder_pkg::*;
#(
    parameter int HIST_AW = 3,
    parameter logic [15:0] RUN_LOCK_MASK = 16'h000F
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fault source and drive quantities
    input wire logic fault_event,
    input wire logic [7:0] fault_code,
    input wire logic [143:0] drive_quantities,
    input wire logic [15:0] runtime_hours,
    input wire logic run_command,
    input wire logic drive_running,
    input wire logic [2:0] control_mode,
    input wire logic [2:0] run_state,
    input wire logic regen_active,
    input wire logic [1:0] limit_action,
    // panel and terminal
    input wire logic fault_display,
    input wire logic stop_reset_key,
    input wire logic ok_key,
    input wire logic terminal_fault_reset,
    // fault state
    output logic fault_active,
    output logic [7:0] active_fault_code
);
    if (HIST_AW < 1 || HIST_AW > 4) begin : g_bad_hist
        $error("HIST_AW must lie in 1..4");
    end

    localparam logic [HIST_AW:0] HIST_DEPTH = (HIST_AW + 1)'(1 << HIST_AW);

    typedef struct packed {
        bus_state_type bus;
        logic ready;
        logic [31:0] rdata;
        logic slverr;
        logic active;
        logic [7:0] code;
        logic [HIST_AW-1:0] head;
        logic [HIST_AW:0] count;
        logic [12:0][15:0] snap;
        logic [15:0] last_hours;
        channel_type channel;
        logic [1:0] lock_select;
        logic [15:0] password;
        logic unlocked;
        logic [3:0] edit_index;
        logic [15:0] edit_value;
        logic pending;
        logic refused_lock;
        logic refused_run;
    } state_type;

    state_type st;
    state_type next_st;
    logic [`KEY_COUNT-1:0] pin_raw;
    logic [`KEY_COUNT-1:0] pin_rise;
    logic [HIST_AW-1:0] slot;
    logic locked;
    logic clear_req;
    logic bus_write;
    logic bus_reset_cmd;
    logic commit_try;

    word_store_if #(.AW(HIST_AW), .DW(8)) hist_if ();
    word_store_if #(.AW(4), .DW(16)) prm_if ();

    function automatic logic mapped(input logic [7:0] a);
        case (a[7:6])
            `REGION_CTRL: mapped = a[5:2] < `CTRL_WORDS;
            `REGION_SNAP: mapped = a[5:2] < `SNAP_WORDS;
            `REGION_HIST: mapped = {1'h0, a[5:2]} < 5'(HIST_DEPTH);
            default: mapped = 1'h0;
        endcase
        mapped = mapped && (a[1:0] == 2'h0);
    endfunction

    assign pin_raw = {terminal_fault_reset, ok_key, stop_reset_key};

    pin_edge_sync #(.WIDTH(`KEY_COUNT)) u_pins (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .raw(pin_raw),
        .level(),
        .rise(pin_rise)
    );

    word_store #(.AW(HIST_AW), .DW(8)) u_history (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .port(hist_if.store)
    );

    word_store #(.AW(4), .DW(16)) u_params (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .port(prm_if.store)
    );

    always_comb begin
        next_st = st;
        slot = paddr[HIST_AW+1:2];
        locked = (st.lock_select != `LOCK_NONE) && !st.unlocked;
        bus_write = st.ready && psel && penable && pwrite && mapped(paddr);
        bus_reset_cmd = bus_write && (paddr == `OFS_BUS_RESET) && pwdata[0];
        commit_try = pin_rise[`KEY_OK] && st.pending;
        // ring slot k sits k places behind the newest entry
        hist_if.raddr = st.head - slot; // RL1
        hist_if.we = fault_event; // RL2
        hist_if.waddr = st.head + HIST_AW'(1); // RL2
        hist_if.wdata = fault_code;
        prm_if.raddr = st.edit_index;
        prm_if.waddr = st.edit_index;
        prm_if.wdata = st.edit_value;
        prm_if.we = commit_try && !locked && !(drive_running && RUN_LOCK_MASK[st.edit_index]); // RL17

        // apb: answer one cycle into the access phase, act on the ready edge
        case (st.bus)
            BUS_IDLE: begin
                if (psel && penable) begin
                    next_st.bus = BUS_ANSWER;
                    next_st.ready = 1'h1;
                    next_st.slverr = !mapped(paddr);
                    next_st.rdata = 32'h0000_0000;
                    if (mapped(paddr)) begin
                        case (paddr[7:6])
                            `REGION_SNAP: next_st.rdata[15:0] = st.snap[paddr[5:2]]; // RL3
                            `REGION_HIST: begin
                                if ({1'h0, slot} < st.count) begin
                                    next_st.rdata[7:0] = hist_if.rdata; // RL1
                                end
                            end
                            default: begin
                                case (paddr)
                                    `OFS_STATUS: next_st.rdata[15:0] = {st.code, 7'h00, st.active};
                                    `OFS_CHANNEL: next_st.rdata[1:0] = st.channel;
                                    `OFS_LOCK_SELECT: next_st.rdata[1:0] = st.lock_select;
                                    `OFS_EDIT_INDEX: next_st.rdata[3:0] = st.edit_index;
                                    `OFS_EDIT_VALUE: next_st.rdata[15:0] = st.edit_value;
                                    `OFS_PARAM_VALUE: next_st.rdata[15:0] = prm_if.rdata;
                                    `OFS_EDIT_STATUS: next_st.rdata[4:0] = {drive_running, st.refused_run,
                                        st.refused_lock, st.pending, locked};
                                    default: next_st.rdata = 32'h0000_0000;
                                endcase
                            end
                        endcase
                    end
                end
            end
            BUS_ANSWER: begin
                next_st.bus = BUS_IDLE;
                next_st.ready = 1'h0;
                next_st.slverr = 1'h0;
            end
            default: begin
                next_st.bus = BUS_IDLE;
                next_st.ready = 1'h0;
            end
        endcase

        if (bus_write) begin
            case (paddr)
                `OFS_CHANNEL: next_st.channel = channel_type'(pwdata[1:0]);
                `OFS_LOCK_SELECT: begin
                    if (!locked) begin
                        next_st.lock_select = pwdata[1:0]; // RL15
                        next_st.unlocked = 1'h0;
                    end
                end
                `OFS_LOCK_PASSWORD: begin
                    if (!locked) begin
                        next_st.password = pwdata[15:0]; // RL15
                    end
                end
                `OFS_UNLOCK: next_st.unlocked = pwdata[15:0] == st.password; // RL15
                `OFS_EDIT_INDEX: next_st.edit_index = pwdata[3:0];
                `OFS_EDIT_VALUE: begin
                    next_st.edit_value = pwdata[15:0];
                    next_st.pending = 1'h1;
                    next_st.refused_lock = 1'h0;
                    next_st.refused_run = 1'h0;
                end
                default: begin
                end
            endcase
        end

        // an OK press settles a pending edit, stored or refused
        if (commit_try) begin
            next_st.pending = bus_write && (paddr == `OFS_EDIT_VALUE); // a new edit in this cycle stays pending
            if (locked) begin
                next_st.refused_lock = 1'h1; // RL15
            end else if (drive_running && RUN_LOCK_MASK[st.edit_index]) begin
                next_st.refused_run = 1'h1; // RL16
            end
        end

        clear_req = (pin_rise[`KEY_STOP] && fault_display) // RL10
            || (st.channel == CH_TERMINAL && pin_rise[`KEY_TERM]) // RL11
            || (st.channel == CH_FIELDBUS && bus_reset_cmd); // RL12

        // a fault in the clearing cycle wins
        if (fault_event) begin
            next_st.active = 1'h1;
            next_st.code = fault_code;
            next_st.head = st.head + HIST_AW'(1); // RL2
            if (st.count < HIST_DEPTH) begin
                next_st.count = st.count + (HIST_AW + 1)'(1); // RL1
            end
            for (int i = 0; i < `QTY_WORDS; i++) begin
                next_st.snap[i] = drive_quantities[16*i +: 16]; // RL3
            end
            next_st.snap[`SNAP_CMD] = 16'h0000;
            next_st.snap[`SNAP_CMD][`DIG_CMD] = run_command; // RL5
            next_st.snap[`SNAP_COND] = 16'h0000;
            next_st.snap[`SNAP_COND][`DIG_MODE] = {1'h0, control_mode}; // RL6
            next_st.snap[`SNAP_COND][`DIG_RUN] = {1'h0, run_state}; // RL7
            next_st.snap[`SNAP_COND][`DIG_REGEN] = {3'h0, regen_active}; // RL8
            next_st.snap[`SNAP_COND][`DIG_LIMIT] = {2'h0, limit_action}; // RL9
            next_st.snap[`SNAP_ACCUM] = runtime_hours; // RL4
            next_st.snap[`SNAP_INTERVAL] = runtime_hours - st.last_hours; // RL4
            next_st.last_hours = runtime_hours;
        end else if (clear_req) begin
            next_st.active = 1'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.bus <= BUS_IDLE;
            st.channel <= CH_PANEL;
            st.lock_select <= `RST_LOCK_SELECT;
            st.password <= `RST_PASSWORD;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign fault_active = st.active;
    assign active_fault_code = st.code;

    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_hist_full;
        fault_event && st.count == HIST_DEPTH |=> st.count == HIST_DEPTH && st.active;
    endproperty
    a_hist_full: assert property (p_hist_full) else $error("history count left full depth"); // RL1

    property p_hist_push;
        fault_event |=> st.head == $past(hist_if.waddr) && st.code == $past(fault_code) && st.count != '0;
    endproperty
    a_hist_push: assert property (p_hist_push) else $error("fault code not pushed as newest"); // RL2

    property p_snap_qty;
        fault_event |=> st.snap[0] == $past(drive_quantities[15:0]) && st.snap[8] == $past(drive_quantities[143:128]);
    endproperty
    a_snap_qty: assert property (p_snap_qty) else $error("quantity snapshot wrong"); // RL3

    property p_snap_hours;
        fault_event |=> st.snap[`SNAP_INTERVAL] == $past(runtime_hours) - $past(st.last_hours);
    endproperty
    a_snap_hours: assert property (p_snap_hours) else $error("interval hours wrong"); // RL4

    property p_snap_cmd;
        fault_event |=> st.snap[`SNAP_CMD] == {15'h0000, $past(run_command)};
    endproperty
    a_snap_cmd: assert property (p_snap_cmd) else $error("command digit wrong"); // RL5

    property p_snap_cond;
        fault_event |=> st.snap[`SNAP_COND] == {2'h0, $past(limit_action), 3'h0, $past(regen_active),
            1'h0, $past(run_state), 1'h0, $past(control_mode)};
    endproperty
    a_snap_cond: assert property (p_snap_cond) else $error("condition digits wrong"); // RL6

    property p_key_clear;
        pin_rise[`KEY_STOP] && fault_display && !fault_event |=> !fault_active;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("stop key did not clear fault"); // RL10

    property p_bus_clear;
        bus_reset_cmd && st.channel == CH_FIELDBUS && !fault_event |=> !fault_active;
    endproperty
    a_bus_clear: assert property (p_bus_clear) else $error("fieldbus reset did not clear"); // RL12

    property p_lock_block;
        locked |-> !prm_if.we;
    endproperty
    a_lock_block: assert property (p_lock_block) else $error("write while locked"); // RL15

    property p_run_refuse;
        commit_try && !locked && drive_running && RUN_LOCK_MASK[st.edit_index] |-> !prm_if.we ##1 st.refused_run;
    endproperty
    a_run_refuse: assert property (p_run_refuse) else $error("run-locked code written while running"); // RL16

    property p_ok_only;
        prm_if.we |-> pin_rise[`KEY_OK] && st.pending ##1 !st.pending;
    endproperty
    a_ok_only: assert property (p_ok_only) else $error("store written without OK"); // RL17
endmodule

// File: test/drive_panel_model.sv
/*
 panel keys and fault-reset terminal as the operator drives them.
 assumes ref_clk is the recorder's clock; pins are sampled by its synchroniser.
*/
`timescale 1ns/1ps
module drive_panel_model #(parameter int HOLDOFF = 4) (
    // clock
    input wire logic ref_clk,
    // recorder state
    input wire logic fault_active,
    // keys and terminal
    output logic stop_reset_key,
    output logic ok_key,
    output logic terminal_fault_reset
);
    int since_fault = 0;
    initial begin
        stop_reset_key = 1'b0;
        ok_key = 1'b0;
        terminal_fault_reset = 1'b0;
    end
    always @(posedge ref_clk) begin
        since_fault <= fault_active ? since_fault + 1 : 0;
    end
    // pin 0 stop, 1 ok, 2 terminal; held three cycles so the synchroniser sees it
    task automatic press(input int pin);
        while (fault_active === 1'b1 && since_fault < HOLDOFF) @(posedge ref_clk);
        @(posedge ref_clk);
        stop_reset_key <= (pin == 0);
        ok_key <= (pin == 1);
        terminal_fault_reset <= (pin > 1);
        repeat (3) @(posedge ref_clk);
        stop_reset_key <= 1'b0;
        ok_key <= 1'b0;
        terminal_fault_reset <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule

// File: test/testbench.sv
/*
 self-checking bench for the fault history recorder, driven over APB.
 assumes the panel model in drive_panel_model.sv.
*/
`timescale 1ns/1ps
`include "fault_recorder_defs.svh"
module testbench;
    import fault_recorder_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, fault_active, stop_reset_key, ok_key, terminal_fault_reset;
    logic fault_event = 1'b0;
    logic run_command = 1'b0;
    logic drive_running = 1'b0;
    logic regen_active = 1'b0;
    logic fault_display = 1'b0;
    logic [7:0] fault_code = 8'h00;
    logic [7:0] active_fault_code;
    logic [143:0] drive_quantities = '0;
    logic [15:0] runtime_hours = 16'h0000;
    logic [15:0] prev_hours = 16'h0000;
    logic [15:0] p, v1, v2;
    logic [2:0] control_mode = 3'h0;
    logic [2:0] run_state = 3'h0;
    logic [1:0] limit_action = 2'h0;
    logic [7:0] hist [8] = '{default: 8'h00};
    logic [32:0] expq [$];
    int error_cnt = 0;
    int check_count = 0;

    fault_history_recorder u_fault_history_recorder (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fault_event(fault_event), .fault_code(fault_code),
        .drive_quantities(drive_quantities), .runtime_hours(runtime_hours), .run_command(run_command),
        .drive_running(drive_running), .control_mode(control_mode), .run_state(run_state),
        .regen_active(regen_active), .limit_action(limit_action), .fault_display(fault_display),
        .stop_reset_key(stop_reset_key), .ok_key(ok_key), .terminal_fault_reset(terminal_fault_reset),
        .fault_active(fault_active), .active_fault_code(active_fault_code));
    drive_panel_model u_drive_panel_model (.ref_clk(ref_clk), .fault_active(fault_active),
        .stop_reset_key(stop_reset_key), .ok_key(ok_key), .terminal_fault_reset(terminal_fault_reset));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // pready is taken at the rising edge; only the watchdog ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
        expq.push_back({err, e});
        apb(a, 1'b0, 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    // one fault with fresh random drive quantities; the history model ages by one slot
    task automatic fault(input int i);
        logic [7:0] c;
        c = 8'($urandom);
        for (int k = 7; k > 0; k--) begin
            hist[k] = hist[k-1];
        end
        hist[0] = c;
        prev_hours = runtime_hours;
        @(posedge ref_clk);
        fault_code <= c;
        drive_quantities <= 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
        runtime_hours <= runtime_hours + 16'($urandom_range(1, 99));
        run_command <= 1'($urandom);
        control_mode <= 3'(i % 6);
        run_state <= 3'(i % 5);
        regen_active <= 1'(i);
        limit_action <= 2'(i % 4);
        drive_running <= 1'(i);
        fault_event <= 1'b1;
        @(posedge ref_clk);
        fault_event <= 1'b0;
    endtask

    always @(negedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check($sformatf("read %h", paddr), {pslverr, prdata}, expq.size() > 0 ? expq.pop_front() : 'x);
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        conclude();
    end

    initial begin
        void'($urandom(50609));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`OFS_STATUS, 32'h0);
        rd(8'h80, 32'h0);
        rd(8'h64, 32'h0);
        wr(8'h68, 32'h0000FFFF);
        rd(8'h68, 32'h0);
        rd(8'hFC, 32'h0, 1'b1);
        rd(8'h02, 32'h0, 1'b1);
        for (int i = 0; i < 9; i++) begin
            fault(i);
            rd(`OFS_STATUS, {16'h0000, hist[0], 8'h01});
            check("active_fault_code", {24'h0, fault_active, active_fault_code}, {24'h0, 1'b1, hist[0]});
            rd(8'h64, {31'h0, run_command});
            rd(8'h68, {16'h0000, 2'h0, limit_action, 3'h0, regen_active, 1'b0, run_state, 1'b0, control_mode});
            rd(8'h6C, {16'h0000, runtime_hours});
            rd(8'h70, {16'h0000, 16'(runtime_hours - prev_hours)});
        end
        for (int k = 0; k < 8; k++) begin
            rd(8'(8'h80 + 4 * k), {24'h0, hist[k]});
        end
        for (int k = 0; k < 9; k++) begin
            rd(8'(8'h40 + 4 * k), {16'h0000, drive_quantities[16*k +: 16]});
        end
        for (int d = 0; d < 2; d++) begin
            fault_display <= 1'(d);
            u_drive_panel_model.press(0);
            rd(`OFS_STATUS, {16'h0000, hist[0], 7'h00, 1'(d == 0)});
            check("fault_active", {32'h0, fault_active}, {32'h0, 1'(d == 0)});
        end
        fault(9);
        u_drive_panel_model.press(2);
        rd(`OFS_STATUS, {16'h0000, hist[0], 8'h01});
        wr(`OFS_CHANNEL, 32'(CH_TERMINAL));
        run_command <= 1'b0;
        u_drive_panel_model.press(2);
        rd(`OFS_STATUS, {16'h0000, hist[0], 8'h00});
        fault(10);
        wr(`OFS_BUS_RESET, 32'h1);
        rd(`OFS_STATUS, {16'h0000, hist[0], 8'h01});
        wr(`OFS_CHANNEL, 32'(CH_FIELDBUS));
        wr(`OFS_BUS_RESET, 32'h1);
        rd(`OFS_STATUS, {16'h0000, hist[0], 8'h00});
        p = 16'($urandom);
        v1 = 16'($urandom);
        v2 = ~v1;
        wr(`OFS_EDIT_INDEX, 32'h5);
        wr(`OFS_EDIT_VALUE, {16'h0000, v1});
        rd(`OFS_PARAM_VALUE, 32'h0);
        rd(`OFS_EDIT_STATUS, 32'h2);
        u_drive_panel_model.press(1);
        rd(`OFS_PARAM_VALUE, {16'h0000, v1});
        wr(`OFS_LOCK_PASSWORD, {16'h0000, p});
        wr(`OFS_LOCK_SELECT, 32'h1);
        rd(`OFS_LOCK_SELECT, 32'h1);
        wr(`OFS_EDIT_VALUE, {16'h0000, v2});
        u_drive_panel_model.press(1);
        rd(`OFS_PARAM_VALUE, {16'h0000, v1});
        wr(`OFS_LOCK_PASSWORD, {16'h0000, ~p});
        wr(`OFS_UNLOCK, {16'h0000, ~p});
        rd(`OFS_EDIT_STATUS, 32'h5);
        wr(`OFS_UNLOCK, {16'h0000, p});
        wr(`OFS_EDIT_VALUE, {16'h0000, v2});
        u_drive_panel_model.press(1);
        rd(`OFS_PARAM_VALUE, {16'h0000, v2});
        rd(`OFS_EDIT_STATUS, 32'h0);
        wr(`OFS_EDIT_INDEX, 32'h2);
        drive_running <= 1'b1;
        wr(`OFS_EDIT_VALUE, {16'h0000, v1});
        u_drive_panel_model.press(1);
        rd(`OFS_PARAM_VALUE, 32'h0);
        rd(`OFS_EDIT_STATUS, 32'h18);
        wr(`OFS_EDIT_INDEX, 32'h6);
        wr(`OFS_EDIT_VALUE, {16'h0000, v2});
        u_drive_panel_model.press(1);
        rd(`OFS_PARAM_VALUE, {16'h0000, v2});
        repeat (3) @(posedge ref_clk);
        conclude();
    end
endmodule
